// ===== src/rom_pkg.sv
// shared constants and carrier types for the synchronous mask rom block
package rom_pkg;

   // ------------------------------------------------------------
   // generation limits
   // ------------------------------------------------------------
   localparam int YMUX_A       = 8;
   localparam int YMUX_B       = 16;
   localparam int YMUX_C       = 32;
   localparam int WORDS_MAX_A  = 4096;
   localparam int WORDS_MAX_B  = 8192;
   localparam int WORDS_MAX_C  = 16384;
   localparam int WORDS_MIN_A  = 16;    // also the depth step
   localparam int WORDS_MIN_B  = 32;    // also the depth step
   localparam int WORDS_MIN_C  = 64;    // also the depth step
   localparam int BITS_MAX_A   = 64;
   localparam int BITS_MAX_B   = 32;
   localparam int BITS_MAX_C   = 16;
   localparam int BITS_MIN_1BA = 2;
   localparam int BITS_MIN_2BA = 4;

   // ------------------------------------------------------------
   // register map (byte addresses) and fields
   // ------------------------------------------------------------
   localparam logic [3:0] OFF_CTRL   = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_COUNT  = 4'h8;
   localparam logic [3:0] OFF_LAST   = 4'hc;
   localparam int         CTRL_FORCE_STBY = 0;
   localparam int         STAT_CFG_OK     = 0;
   localparam int         STAT_LAST_SEL   = 1;
   localparam int         STAT_OE         = 2;
   localparam logic       CTRL_RESET      = 1'b0;
   localparam logic [31:0] COUNT_RESET    = 32'h0000_0000;

   // ------------------------------------------------------------
   // axi4-lite answer codes
   // ------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        awvalid;
      logic [3:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [3:0]  araddr;
      logic        rready;
   } axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_t;

   // ------------------------------------------------------------
   // legality of a generation point
   // ------------------------------------------------------------
   function automatic logic cfg_legal(input int ymux, input int words, input int bits, input int banks);
      int wmax;
      int bmax;
      int bmin;
      int wmin;
      wmax = 0;
      wmin = 1;
      bmax = 0;
      bmin = (banks == 2) ? BITS_MIN_2BA : BITS_MIN_1BA;
      case (ymux)
         YMUX_A: begin
            wmax = WORDS_MAX_A;
            wmin = WORDS_MIN_A;
            bmax = BITS_MAX_A;
         end
         YMUX_B: begin
            wmax = WORDS_MAX_B;
            wmin = WORDS_MIN_B;
            bmax = BITS_MAX_B;
         end
         YMUX_C: begin
            wmax = WORDS_MAX_C;
            wmin = WORDS_MIN_C;
            bmax = BITS_MAX_C;
         end
         default: begin
            wmax = 0;
            bmax = 0;
         end
      endcase
      bmax = bmax * banks;
      // depth runs from its minimum in steps of that same minimum
      return (wmax != 0) && (banks == 1 || banks == 2) && (words >= wmin) && (words <= wmax)
             && (words % wmin == 0) && (bits >= bmin) && (bits <= bmax);
   endfunction

endpackage

// ===== src/rom_array.sv
// fixed-content word array with a combinational lookup
`timescale 1ns/10ps
`default_nettype none
module rom_array #(
   parameter int                    WORDS    = 4096,
   parameter int                    BITS     = 32,
   parameter int                    AW       = $clog2(WORDS),
   parameter bit                    HAS_INIT = 1'b0,
   parameter logic [WORDS*BITS-1:0] INIT     = '0
) (
   input  wire logic [AW-1:0]   addr,
   output logic      [BITS-1:0] word
);

   // ------------------------------------------------------------
   // default image: address and its inverse, repeated
   // ------------------------------------------------------------
   function automatic logic [BITS-1:0] pattern(input logic [AW-1:0] a);
      logic [BITS-1:0] w;
      w = '0;
      for (int i = 0; i < BITS; i++) begin
         w[i] = (i / AW) % 2 == 0 ? a[i % AW] : ~a[i % AW];
      end
      return w;
   endfunction

   // lookup only: no write path exists
   always_comb begin
      if (HAS_INIT) begin
         word = INIT[addr*BITS +: BITS];
      end else begin
         word = pattern(addr);
      end
   end

endmodule
`default_nettype wire

// ===== src/sync_mask_rom_read.sv
// synchronous mask rom read port with an axi4-lite control and status slave
`timescale 1ns/10ps
`default_nettype none
module sync_mask_rom_read #(
   parameter int                    YMUX     = 8,
   parameter int                    BANKS    = 1,
   parameter int                    WORDS    = 4096,
   parameter int                    BITS     = 32,
   parameter bit                    HAS_INIT = 1'b0,
   parameter logic [WORDS*BITS-1:0] INIT     = '0
) (
   input  wire logic                         sys_clk,
   input  wire logic                         srst,
   input  wire logic [$clog2(WORDS)-1:0]     rom_addr,
   input  wire logic                         rom_sel_n,
   input  wire logic                         drive_gate_low,
   output logic      [BITS-1:0]              rom_dout,
   output logic                              rom_dout_oe,
   input  wire rom_pkg::axil_req_t           axi_req,
   output rom_pkg::axil_rsp_t                axi_rsp
);

   // ------------------------------------------------------------
   // derived sizes
   // ------------------------------------------------------------
   localparam int  AW     = $clog2(WORDS);
   localparam logic CFG_OK = rom_pkg::cfg_legal(YMUX, WORDS, BITS, BANKS);

   // ------------------------------------------------------------
   // module state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [BITS-1:0] dout;
      logic            last_sel;
      logic            force_stby;
      logic [31:0]     count;
      logic            aw_have;
      logic [3:0]      aw_addr;
      logic            w_have;
      logic [31:0]     w_data;
      logic [3:0]      w_strb;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // array side
   logic [BITS-1:0] array_word;
   logic            standby;
   logic            array_clk_en;
   logic            access;

   // write channel merge
   logic            aw_take;
   logic            w_take;
   logic            aw_ok;
   logic            w_ok;
   logic [3:0]      wr_addr;
   logic [31:0]     wr_data;
   logic [3:0]      wr_strb;

   // ------------------------------------------------------------
   // word array
   // ------------------------------------------------------------
   rom_array #(
      .WORDS    (WORDS),
      .BITS     (BITS),
      .AW       (AW),
      .HAS_INIT (HAS_INIT),
      .INIT     (INIT)
   ) u_array (
      .addr (rom_addr),
      .word (array_word)
   );

   // ------------------------------------------------------------
   // register address decode
   // ------------------------------------------------------------
   // true for the four words of the map; the rest answer slverr
   function automatic logic reg_mapped(input logic [3:0] a);
      logic hit;
      hit = 1'b0;
      case (a)
         rom_pkg::OFF_CTRL,
         rom_pkg::OFF_STATUS,
         rom_pkg::OFF_COUNT,
         rom_pkg::OFF_LAST: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction

   // ------------------------------------------------------------
   // register read decode
   // ------------------------------------------------------------
   function automatic logic [33:0] reg_read(input logic [3:0] a, input state_t s);
      logic [31:0] d;
      logic [1:0]  r;
      d = 32'h0000_0000;
      r = reg_mapped(a) ? rom_pkg::RESP_OKAY : rom_pkg::RESP_SLVERR;
      case (a)
         rom_pkg::OFF_CTRL: begin
            d[rom_pkg::CTRL_FORCE_STBY] = s.force_stby;
         end
         rom_pkg::OFF_STATUS: begin
            d[rom_pkg::STAT_CFG_OK]   = CFG_OK;
            d[rom_pkg::STAT_LAST_SEL] = s.last_sel;
            d[rom_pkg::STAT_OE]       = ~rom_sel_n & ~drive_gate_low;
         end
         rom_pkg::OFF_COUNT: begin
            d = s.count;
         end
         rom_pkg::OFF_LAST: begin
            d = 32'(s.dout);
         end
         default: begin
            d = 32'h0000_0000;
         end
      endcase
      return {r, d};
   endfunction

   // ------------------------------------------------------------
   // bus handshakes
   // ------------------------------------------------------------
   // a channel is taken only while nothing of it is held and no answer waits
   assign aw_take = axi_req.awvalid & ~state_reg.aw_have & ~state_reg.bvalid;
   assign w_take  = axi_req.wvalid & ~state_reg.w_have & ~state_reg.bvalid;

   // address and data may arrive in either order
   assign aw_ok   = state_reg.aw_have | aw_take;
   assign w_ok    = state_reg.w_have | w_take;

   // held copy wins over the live bus once taken
   assign wr_addr = state_reg.aw_have ? state_reg.aw_addr : axi_req.awaddr;
   assign wr_data = state_reg.w_have ? state_reg.w_data : axi_req.wdata;
   assign wr_strb = state_reg.w_have ? state_reg.w_strb : axi_req.wstrb;

   // ------------------------------------------------------------
   // stand-by and access gating
   // ------------------------------------------------------------
   // deselected or forced idle: the array sleeps on this edge
   assign standby      = rom_sel_n | state_reg.force_stby;

   // deselect drops the capture enable; the combinational lookup still runs but nothing is captured
   assign array_clk_en = ~standby;

   // an access needs a rising edge with select sampled low
   assign access       = array_clk_en;

   // ------------------------------------------------------------
   // access counter step
   // ------------------------------------------------------------
   // a clear meeting an access leaves one: the clear applies and the access still counts
   function automatic logic [31:0] next_count(input logic [31:0] c, input logic clr, input logic acc);
      logic [31:0] n;
      n = c;
      if (clr) begin
         n = acc ? 32'h0000_0001 : rom_pkg::COUNT_RESET;
      end else if (acc) begin
         n = c + 32'h0000_0001;
      end
      return n;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic [33:0] rd;
      rd         = reg_read(axi_req.araddr, state_reg);
      state_next = state_reg;

      // rom access on rising edge; nothing moves between edges
      state_next.last_sel = access;
      if (access) begin
         state_next.dout = array_word;
      end
      // when deselected the held word stays until the next access

      // write channel capture
      if (aw_take) begin
         state_next.aw_have = 1'b1;
         state_next.aw_addr = axi_req.awaddr;
      end
      if (w_take) begin
         state_next.w_have = 1'b1;
         state_next.w_data = axi_req.wdata;
         state_next.w_strb = axi_req.wstrb;
      end

      // access counter; an access in the clearing cycle still counts
      state_next.count = next_count(state_reg.count,
                                    aw_ok && w_ok && wr_addr == rom_pkg::OFF_COUNT && wr_strb != 4'h0,
                                    access);

      // write commit once both address and data are in
      if (aw_ok && w_ok) begin
         state_next.aw_have = 1'b0;
         state_next.w_have  = 1'b0;
         state_next.bvalid  = 1'b1;
         state_next.bresp   = reg_mapped(wr_addr) ? rom_pkg::RESP_OKAY : rom_pkg::RESP_SLVERR;
         case (wr_addr)
            rom_pkg::OFF_CTRL: begin
               if (wr_strb[0]) begin
                  state_next.force_stby = wr_data[rom_pkg::CTRL_FORCE_STBY];
               end
            end
            rom_pkg::OFF_STATUS, rom_pkg::OFF_COUNT, rom_pkg::OFF_LAST: begin
               state_next.bresp = rom_pkg::RESP_OKAY; // status and last ignore writes; a write to count clears it
            end
            default: begin
               state_next.bresp = rom_pkg::RESP_SLVERR;
            end
         endcase
      end

      // answer taken: write channel opens again
      if (state_reg.bvalid && axi_req.bready) begin
         state_next.bvalid = 1'b0;
      end

      // read channel: one outstanding read
      if (state_reg.rvalid) begin
         if (axi_req.rready) begin
            state_next.rvalid = 1'b0;
         end
      end else if (axi_req.arvalid) begin
         state_next.rvalid = 1'b1;
         state_next.rdata  = rd[31:0];
         state_next.rresp  = rd[33:32];
      end

      // synchronous reset wins over everything above
      if (srst) begin
         state_next            = '0;
         state_next.force_stby = rom_pkg::CTRL_RESET;
         state_next.count      = rom_pkg::COUNT_RESET;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      state_reg <= state_next;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // enable is pure logic of the two pins, no clock involved
   assign rom_dout_oe = ~rom_sel_n & ~drive_gate_low;
   assign rom_dout    = state_reg.dout; // latched for a full cycle

   // ------------------------------------------------------------
   // bus answer
   // ------------------------------------------------------------
   always_comb begin
      // write side ready while nothing held and no answer pending
      axi_rsp.awready = ~state_reg.aw_have & ~state_reg.bvalid;
      axi_rsp.wready  = ~state_reg.w_have & ~state_reg.bvalid;

      // write answer stands until bready
      axi_rsp.bvalid  = state_reg.bvalid;
      axi_rsp.bresp   = state_reg.bresp;

      // one read in flight at a time
      axi_rsp.arready = ~state_reg.rvalid;

      // read answer stands until rready
      axi_rsp.rvalid  = state_reg.rvalid;
      axi_rsp.rdata   = state_reg.rdata;
      axi_rsp.rresp   = state_reg.rresp;
   end

endmodule
`default_nettype wire

// ===== verif/rom_reader.sv
// reader-side model that drives the rom select, enable and address pins
`timescale 1ns/10ps
`default_nettype none
module rom_reader #(
   parameter int AW = 6
) (
   input  wire logic          sys_clk,
   input  wire logic          want_sel,
   input  wire logic          want_out,
   input  wire logic [AW-1:0] want_addr,
   output logic      [AW-1:0] rom_addr,
   output logic               rom_sel_n,
   output logic               drive_gate_low
);
   // idle pins from time zero, then moves only in the clock-low phase
   initial begin
      rom_addr       = '0;
      rom_sel_n      = 1'b1;
      drive_gate_low = 1'b1;
      forever begin
         @(negedge sys_clk);
         rom_sel_n      <= ~want_sel;
         drive_gate_low <= ~want_out;
         rom_addr       <= want_addr;
      end
   end
endmodule
`default_nettype wire

// ===== verif/rom_read_chk.sv
// assertions on the rom read port of the mask rom block
`timescale 1ns/10ps
`default_nettype none
module rom_read_chk #(
   parameter int WORDS = 64,
   parameter int BITS  = 16
) (
   input wire logic                     sys_clk,
   input wire logic                     srst,
   input wire logic [$clog2(WORDS)-1:0] rom_addr,
   input wire logic                     rom_sel_n,
   input wire logic                     drive_gate_low,
   input wire logic [BITS-1:0]          rom_dout,
   input wire logic                     rom_dout_oe,
   input wire rom_pkg::axil_req_t       axi_req,
   input wire rom_pkg::axil_rsp_t       axi_rsp
);
   localparam int AW = $clog2(WORDS);
   logic force_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // word held by the default contents
   function automatic logic [BITS-1:0] exp_word(input logic [AW-1:0] a);
      for (int i = 0; i < BITS; i++) begin
         exp_word[i] = ((i / AW) % 2 == 0) ? a[i % AW] : ~a[i % AW];
      end
   endfunction
   // stand-by bit as written with address and data together
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         force_q <= 1'b0;
      end else if (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
                   && axi_req.awaddr == rom_pkg::OFF_CTRL) begin
         force_q <= axi_req.wdata[rom_pkg::CTRL_FORCE_STBY];
      end
   end
   sequence s_take;
      !rom_sel_n && !force_q;
   endsequence
   sequence s_idle2;
      rom_sel_n [*2];
   endsequence
   sequence s_wr_both;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   endsequence
   a_word_on_take: assert property (s_take |=> rom_dout == exp_word($past(rom_addr)))
      else $error("wrong word after access");
   a_hold_idle: assert property ((rom_sel_n || force_q) |=> $stable(rom_dout))
      else $error("output moved without access");
   a_full_cycle: assert property (s_take ##1 s_idle2 |=> rom_dout == exp_word($past(rom_addr, 3)))
      else $error("word not held");
   a_oe_both_low: assert property (rom_dout_oe == (!rom_sel_n && !drive_gate_low))
      else $error("drive enable wrong");
   a_gate_off: assert property ($rose(drive_gate_low) |-> !rom_dout_oe)
      else $error("still driving with gate high");
   a_gate_on: assert property ($fell(drive_gate_low) && !rom_sel_n |-> rom_dout_oe)
      else $error("not driving with gate low");
   a_reset_zero: assert property ($fell(srst) |-> rom_dout == '0)
      else $error("output not cleared by reset");
   a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("no read answer");
   a_write_answer: assert property (s_wr_both |=> axi_rsp.bvalid)
      else $error("no write answer");
endmodule
bind sync_mask_rom_read rom_read_chk #(.WORDS(WORDS), .BITS(BITS)) u_rom_read_chk (
   .sys_clk(sys_clk), .srst(srst), .rom_addr(rom_addr), .rom_sel_n(rom_sel_n),
   .drive_gate_low(drive_gate_low), .rom_dout(rom_dout), .rom_dout_oe(rom_dout_oe),
   .axi_req(axi_req), .axi_rsp(axi_rsp));
`default_nettype wire

// ===== verif/sync_mask_rom_read_test.sv
// self-checking bench for the mask rom read port
`timescale 1ns/10ps
`default_nettype none
module sync_mask_rom_read_test;
   localparam int WORDS = 64;
   localparam int BITS  = 16;
   localparam int AW    = 6;
   logic               sys_clk;
   logic               srst;
   logic               want_sel;
   logic               want_out;
   logic [AW-1:0]      want_addr;
   logic [AW-1:0]      rom_addr;
   logic               rom_sel_n;
   logic               drive_gate_low;
   logic [BITS-1:0]    rom_dout;
   logic               rom_dout_oe;
   rom_pkg::axil_req_t axi_req;
   rom_pkg::axil_rsp_t axi_rsp;
   wire logic [BITS-1:0] dout_bus;
   int                 mismatches;
   int                 samples_checked;
   int                 cycles;
   // tri-state data wire
   assign dout_bus = rom_dout_oe ? rom_dout : {BITS{1'bz}};
   sync_mask_rom_read #(.YMUX(8), .BANKS(1), .WORDS(WORDS), .BITS(BITS)) u_sync_mask_rom_read (
      .sys_clk(sys_clk), .srst(srst), .rom_addr(rom_addr), .rom_sel_n(rom_sel_n),
      .drive_gate_low(drive_gate_low), .rom_dout(rom_dout), .rom_dout_oe(rom_dout_oe),
      .axi_req(axi_req), .axi_rsp(axi_rsp));
   rom_reader #(.AW(AW)) u_rom_reader (
      .sys_clk(sys_clk), .want_sel(want_sel), .want_out(want_out), .want_addr(want_addr),
      .rom_addr(rom_addr), .rom_sel_n(rom_sel_n), .drive_gate_low(drive_gate_low));
   // clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // hang ceiling
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   task stop_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [31:0] word_of(input logic [AW-1:0] a);
      logic [BITS-1:0] w;
      for (int i = 0; i < BITS; i++) begin
         w[i] = ((i / AW) % 2 == 0) ? a[i % AW] : ~a[i % AW];
      end
      return 32'(w);
   endfunction
   // reader request; output then shows the request before it
   task step(input logic s, input logic o, input logic [AW-1:0] a);
      @(posedge sys_clk);
      want_sel <= s;
      want_out <= o;
      want_addr <= a;
      #1;
   endtask
   task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp_resp = rom_pkg::RESP_OKAY);
      logic ta, tw, tb;
      logic [1:0] resp;
      @(posedge sys_clk);
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hf;
      axi_req.bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge sys_clk);
         ta = axi_req.awvalid && axi_rsp.awready;
         tw = axi_req.wvalid && axi_rsp.wready;
         tb = axi_rsp.bvalid;
         resp = axi_rsp.bresp;
         @(posedge sys_clk);
         axi_req.awvalid <= axi_req.awvalid && !ta;
         axi_req.wvalid <= axi_req.wvalid && !tw;
      end
      axi_req.bready <= 1'b0;
      check("bresp", 32'(resp), 32'(exp_resp));
   endtask
   task axi_rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] exp_resp = rom_pkg::RESP_OKAY);
      logic ta, tr;
      logic [31:0] data;
      logic [1:0] resp;
      @(posedge sys_clk);
      axi_req.arvalid <= 1'b1;
      axi_req.araddr <= a;
      axi_req.rready <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         @(negedge sys_clk);
         ta = axi_req.arvalid && axi_rsp.arready;
         tr = axi_rsp.rvalid;
         data = axi_rsp.rdata;
         resp = axi_rsp.rresp;
         @(posedge sys_clk);
         axi_req.arvalid <= axi_req.arvalid && !ta;
      end
      axi_req.rready <= 1'b0;
      check("rresp", 32'(resp), 32'(exp_resp));
      check("rdata", data, exp);
   endtask
   task chk_reset();
      check("dout_rst", 32'(rom_dout), 32'h0);
      check("addr_bits", $bits(rom_addr), AW);
      check("dout_bits", $bits(rom_dout), BITS);
      axi_rd(rom_pkg::OFF_STATUS, 32'h1);
      axi_rd(rom_pkg::OFF_COUNT, 32'h0);
   endtask
   task chk_burst();
      logic [AW-1:0] adr [5] = '{6'h00, 6'h3f, 6'h15, 6'h2a, 6'h01};
      step(1'b1, 1'b1, adr[0]);
      for (int i = 1; i < 5; i++) begin
         step(1'b1, 1'b1, adr[i]);
         check("dout", 32'(dout_bus), word_of(adr[i-1]));
      end
      step(1'b0, 1'b1, 6'h3f);
      check("dout", 32'(dout_bus), word_of(adr[4]));
      step(1'b0, 1'b1, 6'h00);
      check("dout_z", 32'(dout_bus), 32'({BITS{1'bz}}));
      axi_rd(rom_pkg::OFF_COUNT, 32'h5);
      axi_rd(rom_pkg::OFF_LAST, word_of(adr[4]));
   endtask
   task chk_standby();
      for (int i = 0; i < 3; i++) begin
         step(1'b0, 1'b0, AW'(i * 7));
         check("dout_hold", 32'(rom_dout), word_of(6'h01));
      end
      axi_wr(rom_pkg::OFF_LAST, 32'hffff_ffff);
      axi_rd(rom_pkg::OFF_LAST, word_of(6'h01));
      axi_rd(rom_pkg::OFF_COUNT, 32'h5);
   endtask
   task chk_gate();
      for (int s = 0; s < 4; s++) begin
         step(s[0], s[1], 6'h2a);
         @(posedge sys_clk);
         #1;
         check("oe", 32'(rom_dout_oe), 32'(s == 3));
         check("bus", 32'(dout_bus), (s == 3) ? word_of(6'h2a) : 32'({BITS{1'bz}}));
      end
      step(1'b0, 1'b0, 6'h00);
   endtask
   task chk_force();
      axi_wr(rom_pkg::OFF_COUNT, 32'h1);
      axi_rd(rom_pkg::OFF_COUNT, 32'h0);
      axi_wr(rom_pkg::OFF_CTRL, 32'h1);
      axi_rd(rom_pkg::OFF_CTRL, 32'h1);
      step(1'b1, 1'b1, 6'h09);
      step(1'b0, 1'b1, 6'h09);
      check("dout_stby", 32'(dout_bus), word_of(6'h2a));
      axi_rd(rom_pkg::OFF_COUNT, 32'h0);
      axi_wr(rom_pkg::OFF_CTRL, 32'h0);
      step(1'b1, 1'b1, 6'h09);
      step(1'b0, 1'b1, 6'h09);
      check("dout", 32'(dout_bus), word_of(6'h09));
      axi_rd(rom_pkg::OFF_COUNT, 32'h1);
   endtask
   task chk_rereset();
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      #1;
      check("dout_rst", 32'(rom_dout), 32'h0);
      axi_rd(rom_pkg::OFF_CTRL, 32'h0);
      // unmapped word answers slverr both ways
      axi_wr(4'h2, 32'h0, rom_pkg::RESP_SLVERR);
      axi_rd(4'h2, 32'h0, rom_pkg::RESP_SLVERR);
   endtask
   // main sequence
   initial begin
      mismatches = 0;
      samples_checked = 0;
      srst = 1'b1;
      want_sel = 1'b0;
      want_out = 1'b0;
      want_addr = '0;
      axi_req = '0;
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      chk_reset();
      chk_burst();
      chk_standby();
      chk_gate();
      chk_force();
      chk_rereset();
      stop_test();
   end
endmodule
`default_nettype wire
